// >>> status_unit_pkg.sv
// Constants for the bus address and status summary byte logic
package status_unit_pkg;
  localparam logic [4:0] DEFAULT_BUS_ADDR = 5'h12; // Decimal 18
  localparam logic [4:0] ADDR_LIMIT = 5'h1e;       // Highest legal primary address
  // Status byte bit positions
  localparam int BIT_POWER_RESTORED = 7;
  localparam int BIT_REQ_SERVICE = 6;
  localparam int BIT_ERROR = 5;
  localparam int BIT_READY = 4;
  localparam int BIT_HW_ERROR = 3;
  localparam int BIT_SWEEPING = 2;
  localparam int BIT_SWEEP_DONE = 1;
  localparam int BIT_PROG_ERROR = 0;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  // Interface state machine, one-hot
  typedef enum logic [2:0] {
    IDLE_ST = 3'h1,
    LISTEN_ST = 3'h2,
    TALK_ST = 3'h4
  } iface_state_type;
endpackage : status_unit_pkg

// >>> sticky_status_bit.sv
// One status flag with set-over-clear priority
`timescale 1ns/1ps
`default_nettype none
module sticky_status_bit (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic set_in,
  input wire logic clear_in,
  output logic flag_out
);
  logic flag_reg;
  logic flag_next;

  // A set in the same cycle as a clear is kept
  assign flag_next = set_in ? 1'b1 : (clear_in ? 1'b0 : flag_reg);

  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  assign flag_out = flag_reg;
endmodule : sticky_status_bit
`default_nettype wire

// >>> gpib_status_byte_unit.sv
// Bus address store, status summary byte and talker/listener states
// How it works
// - Address 18 is used when nothing else has been stored.
// - New address accepted only in local mode, keypad entry after shifted local.
// - Stored address survives power loss; battery loss falls back to 18.
// - B7 sets after power returns; clears on preset or device clear.
// - B6 follows service request; clears on serial poll or condition gone.
// - B5 set while errors exist; clears on preset, clear, error read.
// - B4 sets when a command finishes; clears on new command, clear, trigger.
// - B3 sets on internal failure; clears on preset, clear, error read.
// - B2 sets at sweep start; clears on sweep stop, preset, clear.
// - B1 sets on normal sweep end; clears on preset or clear.
// - B0 sets on invalid command; clears on preset or clear.
// - Basic talker with serial poll response; no talk-only.
// - Basic listener, dropped when addressed to talk; no listen-only.
// - Parallel poll ignored; controller role never taken or passed.
// - Interface clear drops listener and talker states at the next clock edge.
`timescale 1ns/1ps
`default_nettype none
module gpib_status_byte_unit
  import status_unit_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic POWER_RESTORED,
  input wire logic BATTERY_OK,
  input wire logic LOCAL_MODE,
  input wire logic ADDR_ENTRY_OPEN,
  input wire logic ADDR_WRITE,
  input wire logic [4:0] ADDR_VALUE,
  input wire logic [4:0] NV_ADDR,
  input wire logic NV_ADDR_VALID,
  input wire logic FRONT_PANEL_PRESET_KEY,
  input wire logic DEVICE_CLEAR,
  input wire logic SEL_DEVICE_CLEAR,
  input wire logic PRESET_CMD,
  input wire logic ERROR_READ,
  input wire logic SRQ_CONDITION,
  input wire logic PROG_ERROR_EVENT,
  input wire logic HW_FAULT_EVENT,
  input wire logic CMD_DONE,
  input wire logic DEV_CMD_RECEIVED,
  input wire logic TRIGGER,
  input wire logic SWEEP_START,
  input wire logic SWEEP_END_NORMAL,
  input wire logic SWEEP_ABORT,
  input wire logic IFC,
  input wire logic MY_LISTEN_ADDR,
  input wire logic MY_TALK_ADDR,
  input wire logic UNLISTEN,
  input wire logic UNTALK,
  input wire logic SERIAL_POLL_ENABLE,
  input wire logic SERIAL_POLL_DISABLE,
  input wire logic PARALLEL_POLL,
  input wire logic TAKE_CONTROL,
  output logic [4:0] BUS_ADDR,
  output logic [4:0] NV_ADDR_WRITE_DATA,
  output logic NV_ADDR_WRITE,
  output logic [7:0] STATUS_BYTE,
  output logic SRQ_OUT,
  output logic LISTENER_ACTIVE,
  output logic TALKER_ACTIVE,
  output logic SERIAL_POLL_MODE,
  output logic [7:0] DIO_OUT,
  output logic DIO_OE
);
  logic [4:0] addr_reg;
  logic [4:0] addr_next;
  logic nv_wr_reg;
  logic [4:0] nv_data_reg;
  logic boot_reg;
  logic srq_reg;
  logic srq_cond_reg;
  logic spoll_reg;
  logic spoll_next;
  logic [7:0] dio_reg;
  logic dio_oe_reg;
  logic [7:0] status_bits;
  logic [7:0] set_vec;
  logic [7:0] clr_vec;
  iface_state_type state_reg;
  iface_state_type state_next;

  // Ports come from another clock domain in a real chip; assumed synchronous here
  wire common_clear = FRONT_PANEL_PRESET_KEY | DEVICE_CLEAR | SEL_DEVICE_CLEAR | PRESET_CMD;
  wire addr_ok = ADDR_VALUE <= ADDR_LIMIT;
  wire addr_accept = LOCAL_MODE & ADDR_ENTRY_OPEN & ADDR_WRITE & addr_ok;

  // Address source: battery-backed copy if valid, else factory default
  assign addr_next = addr_accept ? ADDR_VALUE :
    (boot_reg ? ((BATTERY_OK & NV_ADDR_VALID) ? NV_ADDR : DEFAULT_BUS_ADDR) : addr_reg);

  // Loaded once after reset release so the strap-like store is never read by reset
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      addr_reg <= DEFAULT_BUS_ADDR;
      boot_reg <= 1'b1;
      nv_wr_reg <= 1'b0;
      nv_data_reg <= DEFAULT_BUS_ADDR;
    end else begin
      addr_reg <= addr_next;
      boot_reg <= 1'b0;
      nv_wr_reg <= addr_accept;
      nv_data_reg <= addr_accept ? ADDR_VALUE : nv_data_reg;
    end
  end

  // Service request follows its cause; serial poll drops it
  // A new cause in the poll cycle wins, so that request is not lost
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      srq_reg <= 1'b0;
      srq_cond_reg <= 1'b0;
    end else begin
      srq_cond_reg <= SRQ_CONDITION;
      if (!SRQ_CONDITION) begin
        srq_reg <= 1'b0;
      end else if (!srq_cond_reg) begin
        srq_reg <= 1'b1;
      end else if (SERIAL_POLL_ENABLE && TALKER_ACTIVE) begin
        srq_reg <= 1'b0;
      end
    end
  end

  // Set and clear causes per status bit
  assign set_vec[BIT_POWER_RESTORED] = POWER_RESTORED;
  assign clr_vec[BIT_POWER_RESTORED] = common_clear;
  assign set_vec[BIT_REQ_SERVICE] = 1'b0;
  assign clr_vec[BIT_REQ_SERVICE] = 1'b0;
  assign set_vec[BIT_ERROR] = PROG_ERROR_EVENT | HW_FAULT_EVENT;
  assign clr_vec[BIT_ERROR] = common_clear | ERROR_READ;
  assign set_vec[BIT_READY] = CMD_DONE;
  assign clr_vec[BIT_READY] = DEV_CMD_RECEIVED | DEVICE_CLEAR | SEL_DEVICE_CLEAR | TRIGGER;
  assign set_vec[BIT_HW_ERROR] = HW_FAULT_EVENT;
  assign clr_vec[BIT_HW_ERROR] = common_clear | ERROR_READ;
  assign set_vec[BIT_SWEEPING] = SWEEP_START;
  assign clr_vec[BIT_SWEEPING] = SWEEP_END_NORMAL | SWEEP_ABORT | common_clear;
  assign set_vec[BIT_SWEEP_DONE] = SWEEP_END_NORMAL;
  assign clr_vec[BIT_SWEEP_DONE] = common_clear;
  assign set_vec[BIT_PROG_ERROR] = PROG_ERROR_EVENT;
  assign clr_vec[BIT_PROG_ERROR] = common_clear;

  // Seven sticky flags share one cell; bit 6 mirrors the request line
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_flag
      if (g == BIT_REQ_SERVICE) begin : g_srq
        assign status_bits[g] = srq_reg;
      end else begin : g_sticky
        sticky_status_bit u_bit (
          .SYS_CLK(SYS_CLK),
          .RST_B(RST_B),
          .set_in(set_vec[g]),
          .clear_in(clr_vec[g]),
          .flag_out(status_bits[g])
        );
      end
    end
  endgenerate

  // Talker/listener states; parallel poll and control passing have no effect
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      IDLE_ST: begin
        if (MY_TALK_ADDR) state_next = TALK_ST;
        else if (MY_LISTEN_ADDR) state_next = LISTEN_ST;
      end
      LISTEN_ST: begin
        if (MY_TALK_ADDR) state_next = TALK_ST;
        else if (UNLISTEN) state_next = IDLE_ST;
      end
      TALK_ST: begin
        if (UNTALK) state_next = IDLE_ST;
        else if (MY_LISTEN_ADDR && !MY_TALK_ADDR) state_next = LISTEN_ST;
      end
      default: state_next = IDLE_ST;
    endcase
    if (IFC) state_next = IDLE_ST;
  end

  // Serial poll mode is held until the controller disables it
  assign spoll_next = IFC ? 1'b0 : (SERIAL_POLL_ENABLE ? 1'b1 : (SERIAL_POLL_DISABLE ? 1'b0 : spoll_reg));

  // Data drivers only while talking in serial poll mode
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_reg <= IDLE_ST;
      spoll_reg <= 1'b0;
      dio_reg <= 8'h00;
      dio_oe_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      spoll_reg <= spoll_next;
      dio_reg <= status_bits;
      dio_oe_reg <= spoll_next && (state_next == TALK_ST) && !IFC;
    end
  end

  assign BUS_ADDR = addr_reg;
  assign NV_ADDR_WRITE = nv_wr_reg;
  assign NV_ADDR_WRITE_DATA = nv_data_reg;
  assign STATUS_BYTE = status_bits;
  assign SRQ_OUT = srq_reg;
  assign LISTENER_ACTIVE = state_reg == LISTEN_ST;
  assign TALKER_ACTIVE = state_reg == TALK_ST;
  assign SERIAL_POLL_MODE = spoll_reg;
  assign DIO_OUT = dio_reg;
  assign DIO_OE = dio_oe_reg;

  // Interface clear ends both roles next cycle
  a_ifc_drops_roles: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    IFC |=> !LISTENER_ACTIVE && !TALKER_ACTIVE && !DIO_OE) else $error("roles kept after ifc");
  a_talk_ends_listen: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    MY_TALK_ADDR && !IFC |=> TALKER_ACTIVE && !LISTENER_ACTIVE) else $error("listener kept");
  sequence poll_open_s;
    TALKER_ACTIVE && SERIAL_POLL_MODE && !IFC && !UNTALK && !SERIAL_POLL_DISABLE && !MY_LISTEN_ADDR;
  endsequence
  a_poll_byte_out: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    poll_open_s |=> DIO_OE && DIO_OUT == $past(STATUS_BYTE)) else $error("poll byte missing");
  a_addr_local_only: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    $changed(BUS_ADDR) && !$past(boot_reg) |-> $past(LOCAL_MODE)) else $error("address changed remotely");
  a_battery_default: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    boot_reg && !(BATTERY_OK && NV_ADDR_VALID) && !addr_accept |=> BUS_ADDR == DEFAULT_BUS_ADDR)
    else $error("no default addr");
  a_power_bit: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    POWER_RESTORED |=> STATUS_BYTE[7]) else $error("power bit not set");
  a_ready_clear: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    TRIGGER && !CMD_DONE |=> !STATUS_BYTE[4]) else $error("ready not cleared");
  a_sweep_stop: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    SWEEP_ABORT && !SWEEP_START |=> !STATUS_BYTE[2]) else $error("sweep bit stuck");
  a_prog_err: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    PROG_ERROR_EVENT |=> STATUS_BYTE[0] && STATUS_BYTE[5]) else $error("program error lost");
  a_hw_err_read: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    ERROR_READ && !HW_FAULT_EVENT && !PROG_ERROR_EVENT |=> !STATUS_BYTE[3] && !STATUS_BYTE[5]) else $error("hw err kept");
  a_srq_bit: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    !SRQ_CONDITION |=> !SRQ_OUT && !STATUS_BYTE[6]) else $error("srq stuck");
  a_sweep_done: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    SWEEP_END_NORMAL && !SWEEP_START |=> STATUS_BYTE[1] && !STATUS_BYTE[2]) else $error("sweep end");
  a_no_ppoll: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    PARALLEL_POLL && !SERIAL_POLL_MODE && !SERIAL_POLL_ENABLE |=> !DIO_OE) else $error("answered ppoll");
  // Control passing must leave the talker and listener roles alone
  a_no_control: assert property (@(posedge SYS_CLK) disable iff (!RST_B)
    TAKE_CONTROL && !IFC && !MY_TALK_ADDR && !MY_LISTEN_ADDR && !UNLISTEN && !UNTALK
    |=> $stable(TALKER_ACTIVE) && $stable(LISTENER_ACTIVE)) else $error("control taken");
endmodule : gpib_status_byte_unit
`default_nettype wire

// >>> bus_ctl_model.sv
// Bus controller model: sends bus messages and reads the status byte by serial poll
`timescale 1ns/1ps
`default_nettype none
module bus_ctl_model (
  input wire logic SYS_CLK,
  input wire logic [7:0] DIO_OUT,
  input wire logic DIO_OE,
  output logic [8:0] BUS_CMD
);
  // Bits: 0 clear, 1 listen, 2 talk, 3 unlisten, 4 untalk, 5 poll on, 6 poll off, 7 par poll, 8 take ctl
  initial BUS_CMD = 9'h000;
  // One message mask held for one cycle; only changes at the falling edge
  task send(input logic [8:0] m);
    @(negedge SYS_CLK);
    BUS_CMD = m;
    @(negedge SYS_CLK);
    BUS_CMD = 9'h000;
  endtask : send
  // Serial poll; released open-collector lines float high, so a silent unit reads all ones
  task poll(output logic [7:0] sb);
    send(9'h024);
    for (int i = 0; i < 4 && DIO_OE !== 1'b1; i++) @(negedge SYS_CLK);
    @(negedge SYS_CLK);
    sb = DIO_OE ? DIO_OUT : 8'hff;
    send(9'h050);
  endtask : poll
endmodule : bus_ctl_model
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the bus address and status byte unit
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import status_unit_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b;
  logic [15:0] ev;
  logic bat, nvv, loc, ent;
  logic [4:0] addr_v, nv_a, bus_addr, nv_wd;
  logic [8:0] bc;
  logic nv_w, srq, lis, tlk, spm, dio_oe;
  logic [7:0] stat, dio, sb;
  int fail_count = 0, num_checks = 0, cyc = 0;
  // Free-running 50 MHz clock
  always #10 sys_clk = ~sys_clk;
  gpib_status_byte_unit dut_u (.SYS_CLK(sys_clk), .RST_B(rst_b), .POWER_RESTORED(ev[0]), .BATTERY_OK(bat),
    .LOCAL_MODE(loc), .ADDR_ENTRY_OPEN(ent), .ADDR_WRITE(ev[15]), .ADDR_VALUE(addr_v), .NV_ADDR(nv_a),
    .NV_ADDR_VALID(nvv), .FRONT_PANEL_PRESET_KEY(ev[1]), .DEVICE_CLEAR(ev[2]), .SEL_DEVICE_CLEAR(ev[3]),
    .PRESET_CMD(ev[4]), .ERROR_READ(ev[5]), .SRQ_CONDITION(ev[6]), .PROG_ERROR_EVENT(ev[7]),
    .HW_FAULT_EVENT(ev[8]), .CMD_DONE(ev[9]), .DEV_CMD_RECEIVED(ev[10]), .TRIGGER(ev[11]),
    .SWEEP_START(ev[12]), .SWEEP_END_NORMAL(ev[13]), .SWEEP_ABORT(ev[14]), .IFC(bc[0]),
    .MY_LISTEN_ADDR(bc[1]), .MY_TALK_ADDR(bc[2]), .UNLISTEN(bc[3]), .UNTALK(bc[4]),
    .SERIAL_POLL_ENABLE(bc[5]), .SERIAL_POLL_DISABLE(bc[6]), .PARALLEL_POLL(bc[7]), .TAKE_CONTROL(bc[8]),
    .BUS_ADDR(bus_addr), .NV_ADDR_WRITE_DATA(nv_wd), .NV_ADDR_WRITE(nv_w), .STATUS_BYTE(stat),
    .SRQ_OUT(srq), .LISTENER_ACTIVE(lis), .TALKER_ACTIVE(tlk), .SERIAL_POLL_MODE(spm), .DIO_OUT(dio),
    .DIO_OE(dio_oe));
  bus_ctl_model ctl_u (.SYS_CLK(sys_clk), .DIO_OUT(dio), .DIO_OE(dio_oe), .BUS_CMD(bc));
  // Verdict and end of run
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  // Compare one value; case inequality so unknowns fail
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  // Raise a set of event inputs for one cycle
  task pulse(input logic [15:0] m);
    @(negedge sys_clk);
    ev = m;
    @(negedge sys_clk);
    ev = 16'h0000;
  endtask : pulse
  // Reset for 16 cycles, then let the address load on the first edge
  task do_reset;
    rst_b = 1'b0;
    repeat (16) @(negedge sys_clk);
    chk({3'h0, bus_addr}, {3'h0, DEFAULT_BUS_ADDR});
    rst_b = 1'b1;
    repeat (2) @(negedge sys_clk);
  endtask : do_reset
  // Cycle ceiling; the tests need well under a thousand cycles
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      stop_test();
    end
  end
  // Main sequence
  initial begin
    ev = 16'h0000;
    bat = 1'b1;
    nvv = 1'b1;
    loc = 1'b0;
    ent = 1'b1;
    addr_v = 5'h07;
    nv_a = 5'h05;
    do_reset();
    chk({3'h0, bus_addr}, 8'h05);
    nvv = 1'b0;
    do_reset();
    chk({3'h0, bus_addr}, 8'h12);
    nvv = 1'b1;
    bat = 1'b0;
    do_reset();
    chk({3'h0, bus_addr}, 8'h12);
    chk(stat, STATUS_RESET);
    pulse(16'h8000);
    chk({nv_w, 2'b00, bus_addr}, 8'h12);
    loc = 1'b1;
    ent = 1'b0;
    pulse(16'h8000);
    chk({nv_w, 2'b00, bus_addr}, 8'h12);
    ent = 1'b1;
    addr_v = 5'h1f;
    pulse(16'h8000);
    chk({nv_w, 2'b00, bus_addr}, 8'h12);
    addr_v = 5'h1e;
    pulse(16'h8000);
    chk({nv_w, 2'b00, bus_addr}, 8'h9e);
    chk({3'h0, nv_wd}, 8'h1e);
    // Each common clear against every sticky bit except B2, which the sweep end has already cleared
    for (int c = 1; c < 5; c++) begin
      pulse(16'h1381);
      chk(stat, 8'hbd);
      pulse(16'h2000);
      chk(stat, 8'hbb);
      pulse(16'h0001 << c);
      chk(stat, (c == 2 || c == 3) ? 8'h00 : 8'h10);
    end
    // Ready cleared by a new command and by trigger
    for (int k = 10; k < 12; k++) begin
      pulse(16'h0200);
      pulse(16'h0001 << k);
      chk(stat, 8'h00);
    end
    pulse(16'h0180);
    chk(stat, 8'h29);
    pulse(16'h1020);
    chk(stat, 8'h05);
    pulse(16'h4000);
    chk(stat, 8'h01);
    @(negedge sys_clk);
    ev[6] = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk({6'h00, srq, stat[6]}, 8'h03);
    ev[6] = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk({6'h00, srq, stat[6]}, 8'h00);
    ev[6] = 1'b1;
    repeat (3) @(negedge sys_clk);
    ctl_u.send(9'h004);
    ctl_u.send(9'h020);
    chk({6'h00, srq, stat[6]}, 8'h00);
    ctl_u.send(9'h050);
    ev[6] = 1'b0;
    ctl_u.poll(sb);
    chk(sb, 8'h01);
    @(negedge sys_clk);
    chk({6'h00, spm, dio_oe}, 8'h00);
    ctl_u.send(9'h002);
    chk({6'h00, lis, tlk}, 8'h02);
    ctl_u.send(9'h008);
    chk({6'h00, lis, tlk}, 8'h00);
    ctl_u.send(9'h002);
    ctl_u.send(9'h004);
    chk({6'h00, lis, tlk}, 8'h01);
    ctl_u.send(9'h180);
    chk({6'h00, spm, dio_oe}, 8'h00);
    chk({6'h00, lis, tlk}, 8'h01);
    chk(stat, 8'h01);
    ctl_u.send(9'h002);
    chk({6'h00, lis, tlk}, 8'h02);
    ctl_u.send(9'h024);
    chk({4'h0, lis, tlk, spm, dio_oe}, 8'h07);
    ctl_u.send(9'h001);
    chk({4'h0, lis, tlk, spm, dio_oe}, 8'h00);
    stop_test();
  end
endmodule : testbench
`default_nettype wire
